// ===== hw/agsp_scan_seq.sv
// group scan sequencer with group priority control and dedicated sample-and-hold
//
// Summary of operation
// RULE1: enabled dedicated channels are sampled together, then each converted once from hold.
// RULE2: a 3-bit bypass field enables the sample-and-hold of each dedicated channel.
// RULE3: an 8-bit sampling time in the same register sets the sampling duration.
// RULE4: without priority control every trigger is ignored while any group scans.
// RULE5: with priority control a higher group trigger halts a lower scan and starts.
// RULE6: group C enable clear gives groups A and B; set gives A, B and C.
// RULE7: scan mode field value 01b selects group scan mode.
// RULE8: each group has its own two channel selects; its scan converts only those.
// RULE9: each group start trigger comes from its own 6-bit trigger select.
// RULE10: software gives each group a distinct synchronous trigger.
// RULE11: priority arbitration only while the priority enable bit is 1.
// RULE12: restart channel bit 1 resumes a halted scan at its first unconverted channel.
// RULE13: during A, B or C triggers are dropped, or remembered and run after A.
// RULE14: an A trigger halts B and starts A; B rescans afterwards if restart is set.
// RULE15: during B a C trigger is dropped, or run after B when restart is set.
// RULE16: an A or B trigger halts C; C resumes afterwards when restart is set.
// RULE17: a trigger for the group being scanned is always disregarded.
// RULE18: restart channel bit 0 resumes a halted scan from the group's first channel.
// RULE19: continuous bit 1 rescans the lowest group without triggers, resuming after halts.
// RULE20: each lower group keeps a pending flag and its next unconverted channel.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module agsp_scan_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [agsp_pkg::NUM_SRC-1:0] trig_src,
  output logic conv_req,
  output logic [4:0] conv_chan,
  output logic [1:0] conv_grp,
  output logic conv_from_hold,
  output logic conv_abort,
  input wire logic conv_done,
  output logic [2:0] sh_sample,
  output logic [2:0] sh_hold,
  output logic scan_busy,
  output logic scan_end
);
  import agsp_pkg::*;

  typedef struct packed {
    agsp_st_t st;
    logic [1:0] scan_mode;
    logic [2:0][5:0] trsel;
    logic group_c_enable;
    logic priority_control_enable;
    logic low_priority_restart;
    logic restart_channel_select;
    logic continuous_single_scan;
    logic [2:0] sh_bypass_select;
    logic [7:0] sh_sampling_time;
    logic [2:0][31:0] chsel;
    logic [1:0] grp;
    logic [4:0] chan;
    logic [7:0] cnt;
    logic [2:0] pend;
    logic [2:0] partial;
    logic [2:0][5:0] resume;
    logic [2:0] held;
    logic abort;
    logic done_pulse;
    logic [31:0] rdata;
  } agsp_core_t;

  agsp_core_t cur_ff;
  agsp_core_t nxt_st;
  agsp_trig_if trig_bus ();

  // lowest selected channel at or above from; bit 5 flags a hit
  function automatic logic [5:0] next_chan(input logic [31:0] sel, input logic [5:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (sel[i] && (6'(i) >= from))
      begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // dedicated channels at or above from that are selected with their circuit enabled
  function automatic logic [2:0] sh_mask(input logic [31:0] sel, input logic [2:0] byp,
                                         input logic [5:0] from);
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      m[i] = sel[i] && byp[i] && (6'(i) >= from);
    end
    return m;
  endfunction

  agsp_trig_sel u_trig_sel (
    .clk(clk),
    .rst(rst),
    .trig_src(trig_src),
    .trig(trig_bus)
  );

  // trigger selects go out to the selector
  assign trig_bus.sel = cur_ff.trsel; // [RULE9]

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic group_mode;
    logic [1:0] lowest;
    logic [2:0] trig;
    logic [2:0] req;
    logic [2:0] higher;
    logic [2:0] lower;
    logic do_start;
    logic [1:0] s_grp;
    logic [5:0] from;
    logic [5:0] nc;
    logic [2:0] m;
    logic [1:0] g;
    group_mode = 1'b0;
    lowest = GRP_B;
    trig = 3'h0;
    req = 3'h0;
    higher = 3'h0;
    lower = 3'h0;
    do_start = 1'b0;
    s_grp = GRP_A;
    from = 6'h00;
    nc = 6'h00;
    m = 3'h0;
    g = cur_ff.grp;
    nxt_st = cur_ff;
    nxt_st.abort = 1'b0;
    nxt_st.done_pulse = 1'b0;
    nxt_st.rdata = 32'h0000_0000;

    group_mode = (cur_ff.scan_mode == MODE_GROUP_SCAN); // [RULE7]
    lowest = cur_ff.group_c_enable ? GRP_C : GRP_B; // [RULE6]
    trig = trig_bus.pulse & {cur_ff.group_c_enable, 2'b11} & {3{group_mode}}; // [RULE6]
    req = trig | cur_ff.pend;
    if (cur_ff.priority_control_enable && cur_ff.continuous_single_scan && group_mode)
    begin
      req[lowest] = 1'b1; // [RULE19]
    end

    unique case (cur_ff.st)
      ST_IDLE:
      begin
        if (req != 3'h0)
        begin
          do_start = 1'b1;
          s_grp = req[0] ? GRP_A : (req[1] ? GRP_B : GRP_C);
        end
      end
      ST_SAMPLE, ST_CONV:
      begin
        for (int i = 0; i < 3; i++)
        begin
          higher[i] = trig[i] && (2'(i) < g);
          lower[i] = trig[i] && (2'(i) > g); // own group trigger falls in neither [RULE17]
        end
        // lower group triggers are remembered only with restart set [RULE13] [RULE15]
        if (cur_ff.priority_control_enable && cur_ff.low_priority_restart)
        begin
          nxt_st.pend = nxt_st.pend | lower;
        end
        if (cur_ff.st == ST_SAMPLE)
        begin
          nxt_st.cnt = cur_ff.cnt - 8'h01;
          if (cur_ff.cnt <= 8'h01)
          begin
            nxt_st.st = ST_CONV; // [RULE3]
          end
        end
        else if (conv_done)
        begin
          nc = next_chan(cur_ff.chsel[g], 6'(cur_ff.chan) + 6'h01); // [RULE8]
          if (nc[5])
          begin
            nxt_st.chan = nc[4:0];
          end
          else
          begin
            nxt_st.st = ST_IDLE;
            nxt_st.pend[g] = 1'b0;
            nxt_st.partial[g] = 1'b0;
            nxt_st.held = 3'h0;
            nxt_st.done_pulse = 1'b1;
          end
        end
        // preemption only under priority control, otherwise all triggers ignored
        if (cur_ff.priority_control_enable && (higher != 3'h0)) // [RULE4] [RULE5] [RULE11]
        begin
          do_start = 1'b1; // [RULE14] [RULE16]
          s_grp = higher[0] ? GRP_A : GRP_B;
          nxt_st.abort = (cur_ff.st == ST_CONV) && !conv_done;
          // a scan whose last conversion ends in this cycle is complete, not halted
          if ((cur_ff.low_priority_restart || (cur_ff.continuous_single_scan && (g == lowest)))
              && !((cur_ff.st == ST_CONV) && conv_done && !nc[5]))
          begin
            // remember where the halted scan stood [RULE20]
            nxt_st.pend[g] = 1'b1;
            nxt_st.partial[g] = 1'b1;
            if (cur_ff.st == ST_CONV && conv_done)
            begin
              nxt_st.resume[g] = 6'(cur_ff.chan) + 6'h01;
            end
            else if (cur_ff.st == ST_CONV)
            begin
              nxt_st.resume[g] = 6'(cur_ff.chan);
            end
          end
          else
          begin
            nxt_st.pend[g] = 1'b0; // abandoned
            nxt_st.partial[g] = 1'b0;
          end
        end
      end
    endcase

    // start or resume a group scan
    if (do_start)
    begin
      if (cur_ff.restart_channel_select && nxt_st.partial[s_grp])
      begin
        from = nxt_st.resume[s_grp]; // [RULE12]
      end
      else
      begin
        from = 6'h00; // [RULE18]
      end
      nc = next_chan(cur_ff.chsel[s_grp], from); // [RULE8]
      m = sh_mask(cur_ff.chsel[s_grp], cur_ff.sh_bypass_select, from); // [RULE2]
      nxt_st.grp = s_grp;
      nxt_st.resume[s_grp] = from;
      if (!nc[5])
      begin
        // empty selection: the scan ends at once
        nxt_st.st = ST_IDLE;
        nxt_st.pend[s_grp] = 1'b0;
        nxt_st.partial[s_grp] = 1'b0;
        nxt_st.held = 3'h0;
        nxt_st.done_pulse = 1'b1;
      end
      else
      begin
        nxt_st.chan = nc[4:0];
        nxt_st.held = m;
        nxt_st.cnt = cur_ff.sh_sampling_time;
        nxt_st.st = (m != 3'h0) ? ST_SAMPLE : ST_CONV; // [RULE1]
      end
    end

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_CONV_CTRL: nxt_st.scan_mode = reg_wdata[POS_SCAN_MODE +: 2]; // [RULE7]
        OFS_START_TRIG:
        begin
          nxt_st.trsel[0] = reg_wdata[POS_TRIG_A +: 6]; // [RULE9]
          nxt_st.trsel[1] = reg_wdata[POS_TRIG_B +: 6];
        end
        OFS_GRPC_TRIG:
        begin
          nxt_st.trsel[2] = reg_wdata[POS_TRIG_C +: 6];
          nxt_st.group_c_enable = reg_wdata[POS_GRPC_EN]; // [RULE6]
        end
        OFS_PRIO_CTRL:
        begin
          nxt_st.priority_control_enable = reg_wdata[POS_PRIO_EN]; // [RULE11]
          nxt_st.low_priority_restart = reg_wdata[POS_LOW_RESTART];
          nxt_st.restart_channel_select = reg_wdata[POS_RESTART_CH];
          nxt_st.continuous_single_scan = reg_wdata[POS_CONT_SCAN];
        end
        OFS_SH_CTRL:
        begin
          nxt_st.sh_sampling_time = reg_wdata[POS_SH_TIME +: 8]; // [RULE3]
          nxt_st.sh_bypass_select = reg_wdata[POS_SH_BYPASS +: 3]; // [RULE2]
        end
        OFS_CHSEL_A0: nxt_st.chsel[0][15:0] = reg_wdata[15:0]; // [RULE8]
        OFS_CHSEL_A1: nxt_st.chsel[0][31:16] = reg_wdata[15:0];
        OFS_CHSEL_B0: nxt_st.chsel[1][15:0] = reg_wdata[15:0];
        OFS_CHSEL_B1: nxt_st.chsel[1][31:16] = reg_wdata[15:0];
        OFS_CHSEL_C0: nxt_st.chsel[2][15:0] = reg_wdata[15:0];
        OFS_CHSEL_C1: nxt_st.chsel[2][31:16] = reg_wdata[15:0];
        default: ;
      endcase
    end

    // register reads, data valid in the following cycle only
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CONV_CTRL: nxt_st.rdata = {30'h0000_0000, cur_ff.scan_mode};
        OFS_START_TRIG: nxt_st.rdata = {18'h0_0000, cur_ff.trsel[1], 2'h0, cur_ff.trsel[0]};
        OFS_GRPC_TRIG: nxt_st.rdata = {23'h00_0000, cur_ff.group_c_enable, 2'h0, cur_ff.trsel[2]};
        OFS_PRIO_CTRL:
          nxt_st.rdata = {28'h000_0000, cur_ff.continuous_single_scan, cur_ff.restart_channel_select, cur_ff.low_priority_restart, cur_ff.priority_control_enable};
        OFS_SH_CTRL: nxt_st.rdata = {21'h00_0000, cur_ff.sh_bypass_select, cur_ff.sh_sampling_time};
        OFS_CHSEL_A0: nxt_st.rdata = {16'h0000, cur_ff.chsel[0][15:0]};
        OFS_CHSEL_A1: nxt_st.rdata = {16'h0000, cur_ff.chsel[0][31:16]};
        OFS_CHSEL_B0: nxt_st.rdata = {16'h0000, cur_ff.chsel[1][15:0]};
        OFS_CHSEL_B1: nxt_st.rdata = {16'h0000, cur_ff.chsel[1][31:16]};
        OFS_CHSEL_C0: nxt_st.rdata = {16'h0000, cur_ff.chsel[2][15:0]};
        OFS_CHSEL_C1: nxt_st.rdata = {16'h0000, cur_ff.chsel[2][31:16]};
        OFS_STATUS:
          nxt_st.rdata = {18'h0_0000, cur_ff.partial, cur_ff.pend, cur_ff.chan,
                          cur_ff.grp, cur_ff.st != ST_IDLE};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.scan_mode <= RST_SCAN_MODE;
      cur_ff.trsel <= {RST_TRIG, RST_TRIG, RST_TRIG};
      cur_ff.sh_sampling_time <= RST_SH_TIME;
      cur_ff.sh_bypass_select <= RST_SH_BYPASS;
      cur_ff.chsel <= {RST_CHSEL, RST_CHSEL, RST_CHSEL};
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = cur_ff.rdata;
  assign conv_req = (cur_ff.st == ST_CONV);
  assign conv_chan = cur_ff.chan;
  assign conv_grp = cur_ff.grp;
  // held channels are converted from the hold value exactly once [RULE1]
  assign conv_from_hold = ((cur_ff.chan - DED_CH_FIRST) <= (DED_CH_LAST - DED_CH_FIRST))
                          && cur_ff.held[2'(cur_ff.chan - DED_CH_FIRST)];
  assign conv_abort = cur_ff.abort;
  assign sh_sample = (cur_ff.st == ST_SAMPLE) ? cur_ff.held : 3'h0;
  assign sh_hold = (cur_ff.st == ST_CONV) ? cur_ff.held : 3'h0;
  assign scan_busy = (cur_ff.st != ST_IDLE);
  assign scan_end = cur_ff.done_pulse;
endmodule

// ===== inc/agsp_pkg.sv
// constants and types shared by the group scan sequencer files
package agsp_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONV_CTRL = 8'h00;
  localparam logic [7:0] OFS_START_TRIG = 8'h04;
  localparam logic [7:0] OFS_GRPC_TRIG = 8'h08;
  localparam logic [7:0] OFS_PRIO_CTRL = 8'h0C;
  localparam logic [7:0] OFS_SH_CTRL = 8'h10;
  localparam logic [7:0] OFS_CHSEL_A0 = 8'h14;
  localparam logic [7:0] OFS_CHSEL_A1 = 8'h18;
  localparam logic [7:0] OFS_CHSEL_B0 = 8'h1C;
  localparam logic [7:0] OFS_CHSEL_B1 = 8'h20;
  localparam logic [7:0] OFS_CHSEL_C0 = 8'h24;
  localparam logic [7:0] OFS_CHSEL_C1 = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;

  // field positions
  localparam int POS_SCAN_MODE = 0;
  localparam int POS_TRIG_A = 0;
  localparam int POS_TRIG_B = 8;
  localparam int POS_TRIG_C = 0;
  localparam int POS_GRPC_EN = 8;
  localparam int POS_PRIO_EN = 0;
  localparam int POS_LOW_RESTART = 1;
  localparam int POS_RESTART_CH = 2;
  localparam int POS_CONT_SCAN = 3;
  localparam int POS_SH_TIME = 0;
  localparam int POS_SH_BYPASS = 8;

  // values after reset
  localparam logic [1:0] RST_SCAN_MODE = 2'h0;
  localparam logic [5:0] RST_TRIG = 6'h3F;
  localparam logic [7:0] RST_SH_TIME = 8'h18;
  localparam logic [2:0] RST_SH_BYPASS = 3'h0;
  localparam logic [31:0] RST_CHSEL = 32'h0000_0000;

  // encodings and sizes
  localparam logic [1:0] MODE_GROUP_SCAN = 2'h1;
  localparam logic [5:0] TRIG_NONE = 6'h3F;
  localparam int NUM_SRC = 64;
  localparam int NUM_GRP = 3;
  localparam logic [1:0] GRP_A = 2'h0;
  localparam logic [1:0] GRP_B = 2'h1;
  localparam logic [1:0] GRP_C = 2'h2;
  localparam logic [4:0] DED_CH_FIRST = 5'h00;
  localparam logic [4:0] DED_CH_LAST = 5'h02;

  // scan sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} agsp_st_t;

endpackage

// ===== inc/agsp_trig_if.sv
// trigger selects and trigger pulses between sequencer and trigger selector
`timescale 1ns/1ps
interface agsp_trig_if;
  logic [2:0][5:0] sel;
  logic [2:0] pulse;
  modport seq (output sel, input pulse);
  modport sel_side (input sel, output pulse);
endinterface

// ===== hw/agsp_trig_sel.sv
// per-group start trigger selection and rising edge detection
`timescale 1ns/1ps
module agsp_trig_sel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [agsp_pkg::NUM_SRC-1:0] trig_src,
  agsp_trig_if.sel_side trig
);
  import agsp_pkg::*;

  typedef struct packed {
    logic [2:0] prev;
    logic [2:0] pulse;
  } agsp_tsel_t;

  agsp_tsel_t cur_ff;
  agsp_tsel_t nxt_st;
  logic [2:0] level;

  // pick the selected source of each group; the deselect code gives no source
  for (genvar g = 0; g < NUM_GRP; g++)
  begin : g_mux
    assign level[g] = (trig.sel[g] != TRIG_NONE) && trig_src[trig.sel[g]];
  end

  // one pulse per rising edge of the chosen source
  always_comb
  begin
    nxt_st = cur_ff;
    nxt_st.prev = level;
    nxt_st.pulse = level & ~cur_ff.prev;
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign trig.pulse = cur_ff.pulse;
endmodule

// ===== tb/agsp_scan_seq_props.sv
// concurrent checks on the group scan sequencer ports
`timescale 1ns/1ps
module agsp_scan_seq_props
  import agsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic conv_req,
  input wire logic [4:0] conv_chan,
  input wire logic [1:0] conv_grp,
  input wire logic conv_from_hold,
  input wire logic conv_abort,
  input wire logic conv_done,
  input wire logic [2:0] sh_sample,
  input wire logic [2:0] sh_hold,
  input wire logic scan_busy,
  input wire logic scan_end
);
  logic [1:0] mode_ff;
  logic prio_ff;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // mirror of the scan mode and priority enable as software wrote them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= 2'h0;
      prio_ff <= 1'h0;
    end
    else if (reg_wr && reg_addr == OFS_CONV_CTRL)
      mode_ff <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == OFS_PRIO_CTRL)
      prio_ff <= reg_wdata[POS_PRIO_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register, sampling and conversion relations
  AST_SH_FIELDS: assert property (
    reg_rd && reg_addr == OFS_SH_CTRL |=> reg_rdata[31:11] == 21'h0)
    else $error("bits above the sample-hold fields read set");
  AST_SAMPLE_NOT_CONV: assert property ((|sh_sample) |-> !conv_req)
    else $error("conversion requested while sampling");
  AST_HOLD_CHAN: assert property (conv_from_hold |-> conv_chan <= DED_CH_LAST)
    else $error("held value used for a channel without hold circuit");
  AST_HOLD_USED: assert property (
    conv_req && conv_from_hold |-> sh_hold[conv_chan[1:0]])
    else $error("held value converted while its circuit is not holding");
  AST_REQ_BUSY: assert property (conv_req |-> scan_busy)
    else $error("conversion requested while idle");
  AST_REQ_HOLDS: assert property (
    conv_req && !conv_done |=> conv_abort || (conv_req && $stable(conv_chan) && $stable(conv_grp)))
    else $error("open conversion changed without abort");
  AST_ABORT_CAUSE: assert property (
    conv_abort |-> $past(conv_req) && !$past(conv_done) && scan_busy)
    else $error("abort without an open conversion");
  AST_NO_PRIO_KEEP: assert property (
    !prio_ff && conv_req && !conv_done |=> conv_req && !conv_abort)
    else $error("scan interrupted with priority control off");
  AST_MODE_IDLE: assert property (
    mode_ff != MODE_GROUP_SCAN && !scan_busy |=> !scan_busy)
    else $error("scan started outside group scan mode");
  AST_END_ON_FALL: assert property ($fell(scan_busy) |-> scan_end)
    else $error("scan left busy without end pulse");
  AST_SAMPLE_BOUND: assert property ((|sh_sample) |-> ##[1:300] !(|sh_sample))
    else $error("sampling did not end in time");
endmodule

bind agsp_scan_seq agsp_scan_seq_props chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_req(conv_req), .conv_chan(conv_chan), .conv_grp(conv_grp),
  .conv_from_hold(conv_from_hold), .conv_abort(conv_abort), .conv_done(conv_done),
  .sh_sample(sh_sample), .sh_hold(sh_hold), .scan_busy(scan_busy), .scan_end(scan_end));

// ===== tb/agsp_conv_model.sv
// converter stand-in that finishes each requested conversion after a set latency
`timescale 1ns/1ps
module agsp_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_req,
  input wire logic conv_abort,
  input wire logic [3:0] lat,
  output logic conv_done
);
  logic [3:0] cnt_ff;

  // count cycles of an open request and answer once the latency is reached
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      conv_done <= 1'h0;
    end
    else if (!conv_req || conv_done || conv_abort)
    begin
      cnt_ff <= 4'h0;
      conv_done <= 1'h0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 4'h1;
      conv_done <= (cnt_ff + 4'h1 == lat);
    end
  end
endmodule

// ===== tb/agsp_scan_seq_tb.sv
// self-checking bench for the group scan sequencer
`timescale 1ns/1ps
module agsp_scan_seq_tb;
  import agsp_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [3:0] trg = 4'h0;
  logic [55:0] noise = 56'h0;
  logic [3:0] lat = 4'h8;
  logic [31:0] rnd = 32'ha358_2e4e;
  logic [31:0] val;
  logic [31:0] reg_rdata;
  logic conv_req, conv_from_hold, conv_abort, conv_done, scan_busy, scan_end;
  logic [4:0] conv_chan;
  logic [1:0] conv_grp;
  logic [2:0] sh_sample, sh_hold;
  logic [63:0] trig_src;
  logic [63:0] log_sig = 64'h0;
  logic [63:0] c4a;
  int log_n = 0;
  int samp_n = 0;
  int errors = 0;
  int checks_done = 0;

  // sources 1..3 trigger groups a..c, upper sources carry random noise
  assign trig_src = {noise, 4'h0, trg};
  always #12.5 clk = ~clk;

  agsp_scan_seq dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_src(trig_src),
    .conv_req(conv_req), .conv_chan(conv_chan), .conv_grp(conv_grp),
    .conv_from_hold(conv_from_hold), .conv_abort(conv_abort), .conv_done(conv_done),
    .sh_sample(sh_sample), .sh_hold(sh_hold), .scan_busy(scan_busy), .scan_end(scan_end));
  agsp_conv_model conv_u (.clk(clk), .rst(rst), .conv_req(conv_req),
    .conv_abort(conv_abort), .lat(lat), .conv_done(conv_done));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // append channels lo..hi of group g to an expected trace
  function automatic logic [63:0] seq(input logic [63:0] s, input logic [1:0] g,
    input int lo, input int hi);
    for (int c = lo; c <= hi; c++)
      s = {s[55:0], c == 0, g, 5'(c)};
    return s;
  endfunction

  // trace of finished conversions, sampling cycles of channel 0, noise
  always @(posedge clk)
  begin
    rnd <= lfsr(rnd);
    noise <= {rnd[23:0], rnd};
    if (conv_req && conv_done)
    begin
      log_sig <= {log_sig[55:0], conv_from_hold, conv_grp, conv_chan};
      log_n <= log_n + 1;
    end
    if (sh_sample == 3'h1)
      samp_n <= samp_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, e});
    @(posedge clk);
  endtask

  task automatic fire(input int g);
    trg[g + 1] <= 1'h1;
    @(posedge clk);
    trg <= 4'h0;
    @(posedge clk);
  endtask

  task automatic wait_n(input int n);
    for (int i = 0; i < 2000 && log_n < n; i++)
      @(posedge clk);
  endtask

  task automatic settle;
    int idle;
    idle = 0;
    for (int i = 0; i < 3000 && idle < 40; i++)
    begin
      @(posedge clk);
      idle = scan_busy ? 0 : idle + 1;
    end
  endtask

  // trigger g1, then g2 after n conversions, then compare the trace
  task automatic run(input logic [3:0] pc, input int g1, input int g2, input int n,
    input logic [63:0] exp);
    wr(OFS_PRIO_CTRL, {28'h0, pc});
    log_sig = 64'h0;
    log_n = 0;
    fire(g1);
    if (g2 >= 0)
    begin
      wait_n(n);
      fire(g2);
    end
    settle();
    chk(log_sig, exp);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung scan
  initial
  begin
    #1500000;
    errors++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(OFS_START_TRIG, 32'h0000_3F3F);
    rd(OFS_GRPC_TRIG, 32'h0000_003F);
    rd(OFS_SH_CTRL, 32'h0000_0018);
    rd(8'h40, 32'h0000_0000);
    val = rnd;
    wr(OFS_CHSEL_A1, val);
    rd(OFS_CHSEL_A1, {16'h0000, val[15:0]});
    wr(OFS_SH_CTRL, val);
    rd(OFS_SH_CTRL, {21'h0, val[10:0]});
    wr(OFS_STATUS, val);
    rd(OFS_STATUS, 32'h0000_0000);
    wr(OFS_CHSEL_A1, 32'h0000_0000);
    wr(OFS_CONV_CTRL, 32'h0000_0001);
    rd(OFS_CONV_CTRL, 32'h0000_0001);
    wr(OFS_START_TRIG, 32'h0000_0201);
    wr(OFS_GRPC_TRIG, 32'h0000_0103);
    wr(OFS_SH_CTRL, 32'h0000_0105);
    wr(OFS_CHSEL_A0, 32'h0000_0003);
    wr(OFS_CHSEL_B0, 32'h0000_0300);
    wr(OFS_CHSEL_C0, 32'h0000_00F0);
    lat <= {1'h0, rnd[2:0]} + 4'h2;
    run(4'h0, 0, -1, 0, seq(64'h0, GRP_A, 0, 1));
    chk(64'(samp_n), 64'h5);
    lat <= 4'h8;
    c4a = seq(seq(64'h0, GRP_C, 4, 4), GRP_A, 0, 1);
    run(4'h0, 2, 0, 1, seq(64'h0, GRP_C, 4, 7));
    run(4'h7, 2, 0, 1, seq(c4a, GRP_C, 5, 7));
    run(4'h3, 2, 0, 1, seq(c4a, GRP_C, 4, 7));
    run(4'h1, 2, 0, 1, c4a);
    run(4'h7, 0, 1, 0, seq(seq(64'h0, GRP_A, 0, 1), GRP_B, 8, 9));
    run(4'h7, 0, 0, 0, seq(64'h0, GRP_A, 0, 1));
    run(4'h7, 1, 2, 1, seq(seq(64'h0, GRP_B, 8, 9), GRP_C, 4, 7));
    run(4'h1, 1, 0, 1, seq(seq(64'h0, GRP_B, 8, 8), GRP_A, 0, 1));
    wr(OFS_GRPC_TRIG, 32'h0000_0003);
    run(4'h7, 2, -1, 0, 64'h0);
    wr(OFS_GRPC_TRIG, 32'h0000_0103);
    wr(OFS_CONV_CTRL, 32'h0000_0000);
    run(4'h7, 0, -1, 0, 64'h0);
    wr(OFS_CONV_CTRL, 32'h0000_0001);
    log_sig = 64'h0;
    log_n = 0;
    wr(OFS_PRIO_CTRL, 32'h0000_0009);
    wait_n(8);
    chk(log_sig, seq(seq(64'h0, GRP_C, 4, 7), GRP_C, 4, 7));
    wr(OFS_PRIO_CTRL, 32'h0000_0000);
    settle();
    finish_test();
  end
endmodule
